// ---- mrc_consts.svh ----
`ifndef MRC_CONSTS_SVH
`define MRC_CONSTS_SVH
// Opcode fields, bits 13:8 of the instruction word
`define MRC_OP_STORE 6'h00
`define MRC_OP_OR_FILE 6'h04
`define MRC_OP_COPY 6'h08
`define MRC_OP_DEC 6'h03
`define MRC_OP_DEC_SKIP 6'h0B
`define MRC_OP_INC 6'h0A
`define MRC_OP_INC_SKIP 6'h0F
`define MRC_OP_OR_LIT 6'h38
// Load literal: upper four bits 4'hC, two don't-care bits below
`define MRC_OP_LOAD_HI 4'hC
// Jump: upper three bits 3'h5
`define MRC_OP_JUMP_HI 3'h5
// Field positions
`define MRC_DEST_BIT 7
`define MRC_STORE_BIT 7
// Upper-latch bits that feed program counter 12:11
`define MRC_LATCH_HI 4
`define MRC_LATCH_LO 3
// Reset values
`define MRC_PC_RST 13'h0000
`define MRC_ACC_RST 8'h00
`define MRC_INSTR_NOP 14'h0000
// Phase count per instruction cycle
`define MRC_PHASES 4
`endif

// ---- mrc_core.sv ----
`timescale 1ns/10ps
`include "mrc_consts.svh"
// What this block does
// [RQ1] Destination bit picks accumulator or file
// [RQ2] Decrement file, update null flag, one cycle
// [RQ3] Decrement, skip next when null, flags kept
// [RQ4] Increment, skip next when null, flags kept
// [RQ5] Jump loads literal and latch bits, two cycles
// [RQ6] Increment file, update null flag, one cycle
// [RQ7] OR literal into accumulator, update flag
// [RQ8] OR accumulator with file, route result
// [RQ9] Copy file to destination, update flag
// [RQ10] Load literal into accumulator, no flags
// [RQ11] Store accumulator to file, no flags
// [RQ12] Four phases: decode, read, process, write
// [RQ13] Null flag set exactly when result zero
// [RQ14] No-operation only advances program counter
module mrc_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] upper_latch,
  output logic [12:0] prog_counter,
  output logic [6:0] file_addr,
  output logic file_rd,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic [7:0] accum,
  output logic null_flag,
  output logic null_we,
  output logic unhandled
);
  import mrc_pkg::*;
  mrc_phase_t phase;
  logic cycle_end;
  mrc_op_t op;
  // Whole state of the execute logic
  typedef struct packed {
    logic [13:0] ir;
    logic flush;
    logic [7:0] operand;
    logic [7:0] result;
    logic [12:0] pc;
    logic [6:0] faddr;
    logic frd;
    logic [7:0] fwd;
    logic fwe;
    logic [7:0] acc;
    logic nflag;
    logic nwe;
    logic skip;
    logic unh;
  } mrc_core_state_t;
  mrc_core_state_t st_ff;
  mrc_core_state_t nxt_st;
  logic dest_file;
  logic [7:0] lit;
  logic touches_flag;
  logic is_skip;
  logic to_file;
  logic to_acc;

  // Phase sequencer
  mrc_phase_gen u_phase (
    .clk(clk),
    .rst(rst),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // Decoder latches the class at the end of phase one
  mrc_decode u_dec (
    .clk(clk),
    .rst(rst),
    .load(phase == MRC_Q1),
    .instr(instr),
    .op(op)
  );

  assign dest_file = st_ff.ir[`MRC_DEST_BIT];
  assign lit = st_ff.ir[7:0];
  // Ops that write the null flag
  assign touches_flag = (op == MRC_DEC) || (op == MRC_INC) || (op == MRC_OR_LIT) ||
    (op == MRC_OR_FILE) || (op == MRC_COPY);
  assign is_skip = (op == MRC_DEC_SKIP) || (op == MRC_INC_SKIP);
  // Routing per destination bit
  assign to_file = (op == MRC_STORE) ||
    (dest_file && (touches_flag || is_skip) && op != MRC_OR_LIT);
  assign to_acc = (op == MRC_LOAD) || (op == MRC_OR_LIT) ||
    (!dest_file && (touches_flag || is_skip));

  // Execute sequencing across the four phases
  always_comb begin
    nxt_st = st_ff;
    nxt_st.fwe = 1'b0;
    nxt_st.nwe = 1'b0;
    nxt_st.frd = 1'b0;
    unique case (phase)
      MRC_Q1: begin
        // [RQ12] decode phase
        nxt_st.ir = st_ff.flush ? `MRC_INSTR_NOP : instr;
        nxt_st.skip = st_ff.flush;
        nxt_st.flush = 1'b0;
        nxt_st.faddr = instr[6:0];
        nxt_st.frd = !st_ff.flush;
      end
      MRC_Q2: begin
        // [RQ12] read operand, file or literal
        if (op == MRC_OR_LIT || op == MRC_LOAD) begin
          nxt_st.operand = lit;
        end else begin
          nxt_st.operand = file_rdata;
        end
        nxt_st.unh = !st_ff.skip && (op == MRC_OTHER);
      end
      MRC_Q3: begin
        // [RQ12] process data
        nxt_st.result = st_ff.operand;
        if (!st_ff.skip) begin
          unique case (op)
            // [RQ2] [RQ3] decrement
            MRC_DEC, MRC_DEC_SKIP: nxt_st.result = st_ff.operand - 8'h01;
            // [RQ6] [RQ4] increment
            MRC_INC, MRC_INC_SKIP: nxt_st.result = st_ff.operand + 8'h01;
            // [RQ7] [RQ8] inclusive OR
            MRC_OR_LIT, MRC_OR_FILE: nxt_st.result = st_ff.acc | st_ff.operand;
            // [RQ11] store source is accumulator
            MRC_STORE: nxt_st.result = st_ff.acc;
            // [RQ9] [RQ10] copy and load pass operand
            default: nxt_st.result = st_ff.operand;
          endcase
        end
      end
      MRC_Q4: begin
        // [RQ12] write destination and advance
        // [RQ14] counter steps by one
        nxt_st.pc = st_ff.pc + 13'h0001;
        if (!st_ff.skip) begin
          // [RQ1] destination routing
          if (to_file) begin
            nxt_st.fwd = st_ff.result;
            nxt_st.fwe = 1'b1;
          end
          if (to_acc) begin
            nxt_st.acc = st_ff.result;
          end
          // [RQ13] null flag from result
          if (touches_flag) begin
            nxt_st.nflag = (st_ff.result == 8'h00);
            nxt_st.nwe = 1'b1;
          end
          // [RQ3] [RQ4] skip flushes the next fetch
          if (is_skip && st_ff.result == 8'h00) begin
            nxt_st.flush = 1'b1;
          end
          // [RQ5] jump, then a flushed second cycle
          if (op == MRC_JUMP) begin
            nxt_st.pc = {upper_latch[`MRC_LATCH_HI:`MRC_LATCH_LO], st_ff.ir[10:0]};
            nxt_st.flush = 1'b1;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{ir: `MRC_INSTR_NOP, pc: `MRC_PC_RST, acc: `MRC_ACC_RST, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prog_counter = st_ff.pc;
  assign file_addr = st_ff.faddr;
  assign file_rd = st_ff.frd;
  assign file_wdata = st_ff.fwd;
  assign file_we = st_ff.fwe;
  assign accum = st_ff.acc;
  assign null_flag = st_ff.nflag;
  assign null_we = st_ff.nwe;
  assign unhandled = st_ff.unh;

  // Flag-touching ops write the flag from the result
  a_flag_owner: assert property (@(posedge clk) disable iff (rst) // [RQ13]
    (phase == MRC_Q4 && !st_ff.skip && touches_flag) |=>
      (null_we && null_flag == ($past(st_ff.result) == 8'h00)))
    else $error("null flag not updated");
  // Skip and store leave the flag alone
  a_flag_kept: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    (phase == MRC_Q4 && (is_skip || op == MRC_STORE || op == MRC_LOAD)) |=> !null_we)
    else $error("flag touched by flag-free op");
  // Jump target formed from literal and latch
  a_jump_target: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_JUMP) |=>
      (prog_counter == {$past(upper_latch[4:3]), $past(st_ff.ir[10:0])}))
    else $error("jump target wrong");
  // Jump second cycle writes nothing
  a_jump_dead: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_JUMP) |=>
      (!file_we && !null_we)[*4] ##1 (!file_we && !null_we)[*4])
    else $error("jump second cycle not idle");
  // Store writes accumulator to file
  a_store_file: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_STORE) |=>
      (file_we && file_wdata == $past(st_ff.acc)))
    else $error("store did not write file");
  // Load puts literal into accumulator
  a_load_acc: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_LOAD) |=> (accum == $past(lit)))
    else $error("literal not loaded");
  // Destination one goes to file only
  a_dest_file: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    (phase == MRC_Q4 && !st_ff.skip && dest_file && op inside {MRC_DEC, MRC_INC,
      MRC_OR_FILE, MRC_COPY}) |=> (file_we && accum == $past(st_ff.acc)))
    else $error("destination bit ignored");
  // No-operation changes nothing but the program counter
  a_nop_quiet: assert property (@(posedge clk) disable iff (rst) // [RQ14]
    (phase == MRC_Q4 && op == MRC_NOP) |=>
      (!file_we && !null_we && $stable(accum) && prog_counter == $past(st_ff.pc) + 13'h0001))
    else $error("no-operation changed state");
  // Sequencer enable pulse marks phase four
  a_cycle_pulse: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    cycle_end == (phase == MRC_Q4))
    else $error("cycle end pulse misplaced");
  // Operand read requested after each unflushed decode
  a_read_pulse: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    (phase == MRC_Q1) |=> (file_rd == !$past(st_ff.flush)))
    else $error("operand read request wrong");
  // Read request only in phase two
  a_read_slot: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    file_rd |-> (phase == MRC_Q2))
    else $error("read request outside phase two");
  // Write strobes only after the write phase
  a_write_slot: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    (file_we || null_we) |-> (phase == MRC_Q1))
    else $error("write strobe outside write slot");
  // Accumulator and counter move only at the write phase
  a_state_hold: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    (phase != MRC_Q4) |=> ($stable(accum) && $stable(prog_counter)))
    else $error("state moved outside write phase");
  // Every slot but a taken jump steps the counter by one
  a_pc_step: assert property (@(posedge clk) disable iff (rst) // [RQ14]
    (phase == MRC_Q4 && (st_ff.skip || op != MRC_JUMP)) |=>
      (prog_counter == $past(st_ff.pc) + 13'h0001))
    else $error("program counter did not step");
  // Decrement lands in the chosen destination
  a_dec_result: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    (phase == MRC_Q4 && !st_ff.skip && op inside {MRC_DEC, MRC_DEC_SKIP}) |=>
      ((dest_file ? file_wdata : accum) == $past(st_ff.operand) - 8'h01))
    else $error("decrement result wrong");
  // Increment lands in the chosen destination
  a_inc_result: assert property (@(posedge clk) disable iff (rst) // [RQ6]
    (phase == MRC_Q4 && !st_ff.skip && op inside {MRC_INC, MRC_INC_SKIP}) |=>
      ((dest_file ? file_wdata : accum) == $past(st_ff.operand) + 8'h01))
    else $error("increment result wrong");
  // Literal OR goes to the accumulator with a flag write
  a_or_literal: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_OR_LIT) |=>
      (null_we && accum == ($past(st_ff.acc) | $past(lit))))
    else $error("literal OR wrong");
  // File OR lands in the chosen destination
  a_or_file: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_OR_FILE) |=>
      ((dest_file ? file_wdata : accum) == ($past(st_ff.acc) | $past(st_ff.operand))))
    else $error("file OR wrong");
  // Copy writes the flag from the copied value
  a_copy_flag: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_COPY) |=>
      (null_we && null_flag == ($past(st_ff.operand) == 8'h00)))
    else $error("copy flag wrong");
  // Null result of a skip op flushes the next slot
  a_skip_flush: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    (phase == MRC_Q4 && !st_ff.skip && is_skip && st_ff.result == 8'h00) |=>
      st_ff.flush ##1 !file_rd)
    else $error("skip did not flush");
  // Non-null result of a skip op keeps the next slot
  a_skip_pass: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    (phase == MRC_Q4 && !st_ff.skip && is_skip && st_ff.result != 8'h00) |=> !st_ff.flush)
    else $error("skip flushed on non-null result");
  // Jump flushes the slot that follows it
  a_jump_flush: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_JUMP) |=>
      st_ff.flush ##1 !file_rd)
    else $error("jump did not flush");
  // Flushed slot writes nothing
  a_flushed_idle: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    (phase == MRC_Q4 && st_ff.skip) |=> (!file_we && !null_we && $stable(accum)))
    else $error("flushed slot wrote state");
  // Destination zero never writes the file
  a_dest_acc: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    (phase == MRC_Q4 && !st_ff.skip && !dest_file && op inside {MRC_DEC, MRC_INC,
      MRC_OR_FILE, MRC_COPY, MRC_DEC_SKIP, MRC_INC_SKIP}) |=> !file_we)
    else $error("destination bit ignored for accumulator");
  // Store targets the addressed file register
  a_store_addr: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    (phase == MRC_Q4 && !st_ff.skip && op == MRC_STORE) |=>
      (file_addr == $past(st_ff.ir[6:0])))
    else $error("store address wrong");
endmodule

// ---- mrc_core_tb.sv ----
`timescale 1ns/10ps
module mrc_core_tb;
  logic clk, rst; // Core clock and reset
  logic [13:0] instr; // Instruction word
  logic [7:0] file_rdata, upper_latch, file_wdata, accum;
  logic [12:0] prog_counter;
  logic [6:0] file_addr;
  logic file_rd, file_we, null_flag, null_we, unhandled;
  logic [7:0] fmem [128]; // Register file that the core talks to
  logic [7:0] mm [128]; // Model copy of the register file
  logic [13:0] prog [$]; // Directed instruction list
  logic [5:0] tbl [12]; // Opcode fields for random words
  logic [31:0] lf; // Random state
  int fails, num_checks, pc, acc, nf, fl;

  mrc_core DUT (.clk(clk), .rst(rst), .instr(instr), .file_rdata(file_rdata),
    .upper_latch(upper_latch), .prog_counter(prog_counter), .file_addr(file_addr),
    .file_rd(file_rd), .file_wdata(file_wdata), .file_we(file_we), .accum(accum),
    .null_flag(null_flag), .null_we(null_we), .unhandled(unhandled));

  // Free running 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Register file: writes land on the pulse, reads follow the address
  always @(posedge clk) begin
    if (file_we === 1'b1) fmem[file_addr] = file_wdata;
    #1;
    file_rdata = fmem[file_addr];
  end

  // Step of the random source
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Compare and count
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One instruction cycle against the model
  task automatic run(logic [13:0] ins);
    logic [7:0] f, r;
    logic [5:0] o;
    logic d, we, zw, sk, wa, oth, rd, jp;
    int nfl;
    instr = ins;
    upper_latch = lf[7:0];
    lf = nx(lf);
    o = ins[13:8];
    d = ins[7];
    f = mm[ins[6:0]];
    {we, zw, sk, wa, oth, rd, jp} = 7'h00;
    r = 8'h00;
    nfl = 0;
    // Decode: flushed words and no-operation do nothing
    if (fl != 0) begin
    end else if (o == 6'h00 && d) begin
      r = acc[7:0];
      we = 1'b1;
    end else if (o == 6'h00) begin
      oth = (ins[4:0] != 5'h00);
    end else if (o inside {6'h03, 6'h0B, 6'h0A, 6'h0F, 6'h04, 6'h08}) begin
      rd = 1'b1;
      case (o)
        6'h03, 6'h0B: r = f - 8'h01;
        6'h0A, 6'h0F: r = f + 8'h01;
        6'h04: r = f | acc[7:0];
        default: r = f;
      endcase
      zw = !(o inside {6'h0B, 6'h0F});
      sk = !zw && r == 8'h00;
      we = d;
      wa = !d;
    end else if (o == 6'h38) begin
      r = ins[7:0] | acc[7:0];
      wa = 1'b1;
      zw = 1'b1;
    end else if (ins[13:10] == 4'hC) begin
      r = ins[7:0];
      wa = 1'b1;
    end else if (ins[13:11] == 3'h5) begin
      jp = 1'b1;
    end else begin
      oth = 1'b1;
    end
    pc = jp ? {upper_latch[4:3], ins[10:0]} : (pc + 1) & 32'h1FFF;
    nfl = (sk || jp) ? 1 : 0;
    if (wa) acc = r;
    if (zw) nf = (r == 8'h00);
    @(posedge clk);
    #1;
    if (rd) chk("file_rd", file_rd, 1'b1);
    if (fl != 0) chk("file_rd", file_rd, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk("prog_counter", prog_counter, pc[12:0]);
    chk("accum", accum, acc[7:0]);
    chk("file_we", file_we, we);
    if (we) begin
      chk("file_wdata", file_wdata, r);
      chk("file_addr", file_addr, ins[6:0]);
      mm[ins[6:0]] = r;
    end
    chk("null_we", null_we, zw);
    chk("null_flag", null_flag, nf[0]);
    chk("unhandled", unhandled, oth);
    fl = nfl;
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    fails++;
    test_done();
  end

  // Main sequence: directed corner words, then random words
  initial begin
    lf = 32'h450A;
    {fails, num_checks, pc, acc, nf, fl} = '0;
    rst = 1'b1;
    instr = 14'h0000;
    file_rdata = 8'h00;
    upper_latch = 8'h00;
    for (int i = 0; i < 128; i++) begin
      fmem[i] = lf[7:0];
      mm[i] = lf[7:0];
      lf = nx(lf);
    end
    fmem[1] = 8'h01;
    mm[1] = 8'h01;
    fmem[2] = 8'hFF;
    mm[2] = 8'hFF;
    prog = '{14'h3000, 14'h3800, 14'h335A, 14'h0085, 14'h0B81, 14'h3077, 14'h0F02,
      14'h0085, 14'h0A82, 14'h0303, 14'h0484, 14'h0804, 14'h0884, 14'h2ABC, 14'h3011,
      14'h0060, 14'h0205, 14'h3880};
    tbl = '{6'h00, 6'h03, 6'h0B, 6'h0A, 6'h0F, 6'h04, 6'h08, 6'h38, 6'h30, 6'h28,
      6'h2F, 6'h02};
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (prog[i]) run(prog[i]);
    for (int i = 0; i < 150; i++) begin
      lf = nx(lf);
      run({tbl[lf[19:16] % 12], lf[15:8]});
    end
    test_done();
  end
endmodule

// ---- mrc_decode.sv ----
`timescale 1ns/10ps
`include "mrc_consts.svh"
// Registered opcode decoder, sampled in phase one
module mrc_decode (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [13:0] instr,
  output mrc_pkg::mrc_op_t op
);
  import mrc_pkg::*;
  typedef struct packed {
    mrc_op_t op;
  } mrc_dec_state_t;
  mrc_dec_state_t st_ff;
  mrc_dec_state_t nxt_st;
  logic [5:0] hi;
  assign hi = instr[13:8];
  // Classify the instruction word
  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.op = MRC_OTHER;
      if (hi[5:3] == `MRC_OP_JUMP_HI) begin
        nxt_st.op = MRC_JUMP;
      end else if (hi[5:2] == `MRC_OP_LOAD_HI) begin
        // [RQ10] load ignores two opcode bits
        nxt_st.op = MRC_LOAD;
      end else if (hi == `MRC_OP_OR_LIT) begin
        nxt_st.op = MRC_OR_LIT;
      end else if (hi == `MRC_OP_DEC) begin
        nxt_st.op = MRC_DEC;
      end else if (hi == `MRC_OP_DEC_SKIP) begin
        nxt_st.op = MRC_DEC_SKIP;
      end else if (hi == `MRC_OP_INC) begin
        nxt_st.op = MRC_INC;
      end else if (hi == `MRC_OP_INC_SKIP) begin
        nxt_st.op = MRC_INC_SKIP;
      end else if (hi == `MRC_OP_OR_FILE) begin
        nxt_st.op = MRC_OR_FILE;
      end else if (hi == `MRC_OP_COPY) begin
        nxt_st.op = MRC_COPY;
      end else if (hi == `MRC_OP_STORE && instr[`MRC_STORE_BIT]) begin
        nxt_st.op = MRC_STORE;
      end else if (hi == `MRC_OP_STORE && instr[6:0] == 7'h00) begin
        // [RQ14] no-operation, bits 6:5 free
        nxt_st.op = MRC_NOP;
      end else if (hi == `MRC_OP_STORE && instr[4:0] == 5'h00) begin
        nxt_st.op = MRC_NOP;
      end
    end
  end
  // Decode register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{op: MRC_NOP};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign op = st_ff.op;
endmodule

// ---- mrc_phase_gen.sv ----
`timescale 1ns/10ps
`include "mrc_consts.svh"
// Phase sequencer: one-cycle pulse per instruction cycle, in phase four
module mrc_phase_gen (
  input wire logic clk,
  input wire logic rst,
  output mrc_pkg::mrc_phase_t phase,
  output logic cycle_end
);
  import mrc_pkg::*;
  // Whole state of the sequencer
  typedef struct packed {
    mrc_phase_t ph;
    logic last;
  } mrc_pg_state_t;
  mrc_pg_state_t st_ff;
  mrc_pg_state_t nxt_st;
  // Next phase
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.ph)
      MRC_Q1: nxt_st.ph = MRC_Q2;
      MRC_Q2: nxt_st.ph = MRC_Q3;
      MRC_Q3: nxt_st.ph = MRC_Q4;
      MRC_Q4: nxt_st.ph = MRC_Q1;
    endcase
    nxt_st.last = (nxt_st.ph == MRC_Q4);
  end
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{ph: MRC_Q1, last: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign phase = st_ff.ph;
  assign cycle_end = st_ff.last;
  // Phases walk in order
  a_phase_order: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    (st_ff.ph == MRC_Q1) |=> (st_ff.ph == MRC_Q2) ##1 (st_ff.ph == MRC_Q3)
      ##1 (st_ff.ph == MRC_Q4) ##1 (st_ff.ph == MRC_Q1))
    else $error("phase sequence broken");
endmodule

// ---- mrc_pkg.sv ----
package mrc_pkg;
  // Four phases of one instruction cycle
  typedef enum logic [1:0] {
    MRC_Q1,
    MRC_Q2,
    MRC_Q3,
    MRC_Q4
  } mrc_phase_t;
  // Decoded operation classes
  typedef enum logic [3:0] {
    MRC_NOP,
    MRC_DEC,
    MRC_DEC_SKIP,
    MRC_INC,
    MRC_INC_SKIP,
    MRC_JUMP,
    MRC_OR_LIT,
    MRC_OR_FILE,
    MRC_COPY,
    MRC_LOAD,
    MRC_STORE,
    MRC_OTHER
  } mrc_op_t;
endpackage
